/* File: verilog/windowed_watchdog_defines.svh */
// What this block does
// - timeout resets chip or raises interrupt
// - reset enabled: unfed timeout resets whole chip
// - windowed: reload accepted only inside window
// - warning interrupt at programmable count
// - 24-bit loadable counter, fixed prescaler
// - period 1024 ticks upward, step four
// - enable locks until hardware or watchdog reset
// - wrong feed order fires event at once
// - protected reload value writable after warning
// - flag marks watchdog-caused chip reset
// - tick from 1 MHz oscillator via divider
// - optional counting through deep sleep
//
// Purpose: register map, field positions and reset values of the watchdog
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef WINDOWED_WATCHDOG_DEFINES_SVH
`define WINDOWED_WATCHDOG_DEFINES_SVH

// register byte offsets
`define ADDR_MODE     6'h00
`define ADDR_RELOAD   6'h04
`define ADDR_FEED     6'h08
`define ADDR_COUNT    6'h0C
`define ADDR_WARN     6'h10
`define ADDR_WINDOW   6'h14
`define ADDR_CLKDIV   6'h18
`define ADDR_INTSTAT  6'h1C
`define ADDR_INTMASK  6'h20
`define ADDR_RSTFLAG  6'h24

// mode bits
`define MODE_EN       0
`define MODE_RSTEN    1
`define MODE_PROTECT  2
`define MODE_SLEEPRUN 3
`define MODE_W        4

// interrupt status bits
`define INT_TIMEOUT   0
`define INT_WARN      1
`define INT_FEEDERR   2
`define INT_W         3

// reset values and constants
`define RELOAD_RST    24'hFFFFFF
`define RELOAD_MIN    24'h0000FF
`define WINDOW_RST    24'hFFFFFF
`define WARN_RST      24'h000000
`define COUNT_RST     24'hFFFFFF
`define CLKDIV_RST    8'h00
`define FEED_KEY1     8'hAA
`define FEED_KEY2     8'h55
`define PRESC_LAST    2'h3
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

/* File: verilog/windowed_watchdog_pkg.sv */
// Purpose: shared types of the watchdog
// Assumes: nothing
// Notes:   states of the two-step feed sequence
package windowed_watchdog_pkg;

   typedef enum logic {
      FEED_IDLE,
      FEED_ARMED
   } feedState_t;

endpackage : windowed_watchdog_pkg

/* File: verilog/watchdog_tick_clock.sv */
// Purpose: makes the watchdog tick from the always-on 1 MHz oscillator
// Assumes: oscillator level is synchronous to sys_clk
// Notes:   one tick pulse per (divider + 1) oscillator rising edges
`timescale 1ns/10ps
`include "windowed_watchdog_defines.svh"

module watchdog_tick_clock #(
   parameter int DIV_W = 8                // divider width
) (
   input  wire logic             sys_clk, // system clock
   input  wire logic             rst,     // synchronous reset, high
   input  wire logic             oscIn,   // 1 MHz oscillator level
   input  wire logic [DIV_W-1:0] divSel,  // divide by divSel + 1
   output logic                  tickPulse // one-cycle tick
);

   logic             oscPrev_ff;
   logic [DIV_W-1:0] divCnt_ff;
   logic             oscRise;

   assign oscRise = oscIn & ~oscPrev_ff;

   // oscillator edge detect
   always_ff @(posedge sys_clk) begin
      if (rst) oscPrev_ff <= 1'b0;
      else     oscPrev_ff <= oscIn;
   end

   // software-programmable divider
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         divCnt_ff <= '0;
         tickPulse <= 1'b0;
      end else begin
         tickPulse <= 1'b0;
         if (oscRise) begin
            if (divCnt_ff >= divSel) begin
               divCnt_ff <= '0;
               tickPulse <= 1'b1;
            end else begin
               divCnt_ff <= divCnt_ff + 1'b1;
            end
         end
      end
   end

   a_tick_needs_edge: assert property (@(posedge sys_clk) disable iff (rst)
      tickPulse |-> $past(oscRise))
      else $error("tick without oscillator edge");

endmodule : watchdog_tick_clock

/* File: verilog/windowed_watchdog_timer.sv */
// Purpose: windowed watchdog with AXI4-Lite registers
// Assumes: porRst is the power-on reset, rst every other chip reset
// Notes:   wdResetReq is a one-cycle request to the chip reset logic
`timescale 1ns/10ps
`include "windowed_watchdog_defines.svh"

module windowed_watchdog_timer
   import windowed_watchdog_pkg::*;
#(
   parameter int CNT_W = 24,              // timeout counter width
   parameter int DIV_W = 8                // tick divider width
) (
   input  wire logic        sys_clk,       // 40 MHz system clock
   input  wire logic        rst,           // synchronous reset, high
   input  wire logic        porRst,        // power-on reset, high
   input  wire logic        alwaysOn1mhzOsc, // always-on oscillator level
   input  wire logic        deepSleep,     // chip in deep sleep
   input  wire logic [5:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [5:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   output logic             wdResetReq,    // chip reset request pulse
   output logic             irq            // level interrupt
);

   logic [5:0]        awAddr_ff;
   logic              awHeld_ff;
   logic [31:0]       wData_ff;
   logic [3:0]        wStrb_ff;
   logic              wHeld_ff;
   logic              wrFire;
   logic [`MODE_W-1:0] mode_ff;
   logic [CNT_W-1:0]  reload_ff;
   logic [CNT_W-1:0]  warn_ff;
   logic [CNT_W-1:0]  window_ff;
   logic [CNT_W-1:0]  count_ff;
   logic [DIV_W-1:0]  clkDiv_ff;
   logic [`INT_W-1:0] intStat_ff;
   logic [`INT_W-1:0] intMask_ff;
   logic [`INT_W-1:0] nxt_intStat;
   logic              rstFlag_ff;
   logic              running_ff;
   logic [1:0]        presc_ff;
   feedState_t        feedState_ff;
   logic              tickPulse;
   logic              advance;
   logic              prescTick;
   logic              feedWr;
   logic              feedOk;
   logic              feedBad;
   logic              windowErr;
   logic              timeoutHit;
   logic              wdEvent;
   logic              wdReset;
   logic              reloadWrOk;
   logic [31:0]       wrWord;
   logic [31:0]       rdWord;
   logic              rdMapped;

   // byte-enable merge of a write onto an old value, given as zero for register writes
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[8*i +: 8] = data[8*i +: 8];
      end
      return res;
   endfunction : mergeBytes

   // write to the register at a given offset this cycle
   function automatic logic isWr(input logic [5:0] off);
      return wrFire && (awAddr_ff == off);
   endfunction : isWr

   // ---------------- AXI4-Lite write channel ----------------
   assign s_axi_awready = ~awHeld_ff;
   assign s_axi_wready  = ~wHeld_ff;
   assign wrFire        = awHeld_ff & wHeld_ff & ~s_axi_bvalid;

   // address and data are taken in either order, then committed together
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= '0;
      end else if (s_axi_awvalid && !awHeld_ff) begin
         awHeld_ff <= 1'b1;
         awAddr_ff <= s_axi_awaddr;
      end else if (wrFire) begin
         awHeld_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wHeld_ff <= 1'b0;
         wData_ff <= '0;
         wStrb_ff <= '0;
      end else if (s_axi_wvalid && !wHeld_ff) begin
         wHeld_ff <= 1'b1;
         wData_ff <= s_axi_wdata;
         wStrb_ff <= s_axi_wstrb;
      end else if (wrFire) begin
         wHeld_ff <= 1'b0;
      end
   end

   // write response, unmapped and read-only offsets answer SLVERR
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awAddr_ff > `ADDR_RSTFLAG || awAddr_ff == `ADDR_COUNT ||
                          awAddr_ff[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- AXI4-Lite read channel ----------------
   assign s_axi_arready = ~s_axi_rvalid;

   // read mux
   always_comb begin
      rdWord   = '0;
      rdMapped = 1'b1;
      unique case (s_axi_araddr)
         `ADDR_MODE:    rdWord[`MODE_W-1:0] = mode_ff;
         `ADDR_RELOAD:  rdWord[CNT_W-1:0]   = reload_ff;
         `ADDR_FEED:    rdWord              = '0;
         `ADDR_COUNT:   rdWord[CNT_W-1:0]   = count_ff;
         `ADDR_WARN:    rdWord[CNT_W-1:0]   = warn_ff;
         `ADDR_WINDOW:  rdWord[CNT_W-1:0]   = window_ff;
         `ADDR_CLKDIV:  rdWord[DIV_W-1:0]   = clkDiv_ff;
         `ADDR_INTSTAT: rdWord[`INT_W-1:0]  = intStat_ff;
         `ADDR_INTMASK: rdWord[`INT_W-1:0]  = intMask_ff;
         `ADDR_RSTFLAG: rdWord[0]           = rstFlag_ff;
         default:       rdMapped            = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdWord;
         s_axi_rresp  <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- configuration registers ----------------
   assign wrWord     = mergeBytes(32'h00000000, wData_ff, wStrb_ff);
   assign reloadWrOk = ~mode_ff[`MODE_PROTECT] | (count_ff <= warn_ff);

   // mode bits are set-only; a watchdog reset or rst clears them
   always_ff @(posedge sys_clk) begin
      if (rst || wdReset) begin
         mode_ff <= '0;
      end else if (isWr(`ADDR_MODE)) begin
         mode_ff <= mode_ff | wrWord[`MODE_W-1:0];
      end
   end

   // reload value, never below the smallest period
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reload_ff <= `RELOAD_RST;
      end else if (isWr(`ADDR_RELOAD) && reloadWrOk) begin
         reload_ff <= (wrWord[CNT_W-1:0] < `RELOAD_MIN) ? `RELOAD_MIN
                      : wrWord[CNT_W-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         warn_ff   <= `WARN_RST;
         window_ff <= `WINDOW_RST;
         clkDiv_ff <= `CLKDIV_RST;
         intMask_ff <= '0;
      end else begin
         if (isWr(`ADDR_WARN))    warn_ff    <= wrWord[CNT_W-1:0];
         if (isWr(`ADDR_WINDOW))  window_ff  <= wrWord[CNT_W-1:0];
         if (isWr(`ADDR_CLKDIV))  clkDiv_ff  <= wrWord[DIV_W-1:0];
         if (isWr(`ADDR_INTMASK)) intMask_ff <= wrWord[`INT_W-1:0];
      end
   end

   // ---------------- tick and prescaler ----------------
   watchdog_tick_clock #(
      .DIV_W     (DIV_W)
   ) u_tick (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .oscIn     (alwaysOn1mhzOsc),
      .divSel    (clkDiv_ff),
      .tickPulse (tickPulse)
   );

   // counting halts in deep sleep unless sleep-run is set
   assign advance   = tickPulse & running_ff &
                      (~deepSleep | mode_ff[`MODE_SLEEPRUN]);
   assign prescTick = advance & (presc_ff == `PRESC_LAST);

   always_ff @(posedge sys_clk) begin
      if (rst || wdReset || feedOk) presc_ff <= '0;
      else if (advance)             presc_ff <= presc_ff + 1'b1;
   end

   // ---------------- feed sequence ----------------
   assign feedWr    = isWr(`ADDR_FEED);
   assign feedOk    = feedWr && feedState_ff == FEED_ARMED &&
                      wData_ff[7:0] == `FEED_KEY2 && mode_ff[`MODE_EN];
   assign feedBad   = feedWr && mode_ff[`MODE_EN] &&
                      ((feedState_ff == FEED_IDLE  && wData_ff[7:0] != `FEED_KEY1) ||
                       (feedState_ff == FEED_ARMED && wData_ff[7:0] != `FEED_KEY2));
   assign windowErr = running_ff && (count_ff > window_ff);

   // a write anywhere else between the two keys breaks the sequence
   always_ff @(posedge sys_clk) begin
      if (rst || wdReset) begin
         feedState_ff <= FEED_IDLE;
      end else if (wrFire) begin
         unique case (feedState_ff)
            FEED_IDLE:  feedState_ff <= (feedWr && wData_ff[7:0] == `FEED_KEY1)
                                        ? FEED_ARMED : FEED_IDLE;
            FEED_ARMED: feedState_ff <= FEED_IDLE;
         endcase
      end
   end

   // ---------------- counter and events ----------------
   assign timeoutHit = prescTick && (count_ff == '0);
   assign wdEvent    = mode_ff[`MODE_EN] &&
                       (timeoutHit || feedBad || (feedOk && windowErr));
   assign wdReset    = wdEvent && mode_ff[`MODE_RSTEN];

   // first good feed after enable starts the count
   always_ff @(posedge sys_clk) begin
      if (rst || wdReset)             running_ff <= 1'b0;
      else if (feedOk && !windowErr)  running_ff <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst || wdReset) begin
         count_ff <= `COUNT_RST;
      end else if ((feedOk && !windowErr) || wdEvent) begin
         count_ff <= reload_ff;
      end else if (prescTick) begin
         count_ff <= count_ff - 1'b1;
      end
   end

   // reset request to the chip
   always_ff @(posedge sys_clk) begin
      if (rst) wdResetReq <= 1'b0;
      else     wdResetReq <= wdReset;
   end

   // sticky status, a new event wins over a write-one clear
   always_comb begin
      nxt_intStat = intStat_ff;
      if (isWr(`ADDR_INTSTAT)) nxt_intStat = nxt_intStat & ~wrWord[`INT_W-1:0];
      if (wdEvent && !mode_ff[`MODE_RSTEN]) begin
         nxt_intStat[`INT_TIMEOUT] = timeoutHit | nxt_intStat[`INT_TIMEOUT];
         nxt_intStat[`INT_FEEDERR] = ~timeoutHit | nxt_intStat[`INT_FEEDERR];
      end
      if (prescTick && count_ff == warn_ff && mode_ff[`MODE_EN]) begin
         nxt_intStat[`INT_WARN] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) intStat_ff <= '0;
      else     intStat_ff <= nxt_intStat;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) irq <= 1'b0;
      else     irq <= |(nxt_intStat & intMask_ff);
   end

   // reset-cause flag lives on porRst only, set wins over clear
   always_ff @(posedge sys_clk) begin
      if (porRst) begin
         rstFlag_ff <= 1'b0;
      end else if (wdReset) begin
         rstFlag_ff <= 1'b1;
      end else if (isWr(`ADDR_RSTFLAG) && wrWord[0]) begin
         rstFlag_ff <= 1'b0;
      end
   end

   // ---------------- checks ----------------
   sequence s_feedKey1;
      feedWr && feedState_ff == FEED_IDLE && wData_ff[7:0] == `FEED_KEY1;
   endsequence

   sequence s_feedWrongSecond;
      feedWr && mode_ff[`MODE_EN] && feedState_ff == FEED_ARMED &&
      wData_ff[7:0] != `FEED_KEY2;
   endsequence

   a_timeout_reset: assert property (@(posedge sys_clk) disable iff (rst)
      timeoutHit && mode_ff[`MODE_EN] && mode_ff[`MODE_RSTEN]
      |=> wdResetReq && rstFlag_ff && count_ff == `COUNT_RST)
      else $error("timeout did not reset chip");

   a_timeout_irq: assert property (@(posedge sys_clk) disable iff (rst)
      timeoutHit && mode_ff[`MODE_EN] && !mode_ff[`MODE_RSTEN]
      |=> intStat_ff[`INT_TIMEOUT] && !wdResetReq)
      else $error("timeout did not interrupt");

   a_window_early: assert property (@(posedge sys_clk) disable iff (rst)
      feedOk && count_ff > window_ff && running_ff |-> wdEvent)
      else $error("early feed accepted");

   a_warning_set: assert property (@(posedge sys_clk) disable iff (rst)
      prescTick && mode_ff[`MODE_EN] && count_ff == warn_ff
      |=> intStat_ff[`INT_WARN])
      else $error("warning missed");

   a_enable_locked: assert property (@(posedge sys_clk) disable iff (rst)
      mode_ff[`MODE_EN] && !wdReset |=> mode_ff[`MODE_EN])
      else $error("enable cleared by software");

   a_bad_feed: assert property (@(posedge sys_clk) disable iff (rst)
      s_feedKey1 ##[1:1000] s_feedWrongSecond |-> wdEvent)
      else $error("bad feed order ignored");

   a_reload_protect: assert property (@(posedge sys_clk) disable iff (rst)
      mode_ff[`MODE_PROTECT] && count_ff > warn_ff |=> $stable(reload_ff))
      else $error("protected reload changed");

   a_min_period: assert property (@(posedge sys_clk) disable iff (rst)
      reload_ff >= `RELOAD_MIN)
      else $error("reload below minimum");

   a_flag_kept: assert property (@(posedge sys_clk) disable iff (porRst)
      rstFlag_ff && !isWr(`ADDR_RSTFLAG) |=> rstFlag_ff)
      else $error("reset flag lost");

   a_sleep_hold: assert property (@(posedge sys_clk) disable iff (rst)
      deepSleep && !mode_ff[`MODE_SLEEPRUN] && !feedOk && !wdEvent
      |=> $stable(count_ff))
      else $error("counter ran in deep sleep");

endmodule : windowed_watchdog_timer

/* File: verif/windowed_watchdog_timer_tb.sv */
// Purpose: self-checking bench of the windowed watchdog timer
// Assumes: oscillator toggled every sys_clk cycle, so a tick is two cycles
// Notes:   reload values drawn from $urandom with a fixed seed
`timescale 1ns/10ps
`include "windowed_watchdog_defines.svh"

module windowed_watchdog_timer_tb;
   logic        sys_clk   = 1'h0;
   logic        rst       = 1'h1;
   logic        porRst    = 1'h1;
   logic        osc       = 1'h0;
   logic        deepSleep = 1'h0;
   logic [5:0]  awaddr    = 6'h00;
   logic [5:0]  araddr    = 6'h00;
   logic [31:0] wdata     = 32'h0;
   logic        awvalid   = 1'h0;
   logic        wvalid    = 1'h0;
   logic        arvalid   = 1'h0;
   logic [31:0] rdata;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic        awready;
   logic        wready;
   logic        arready;
   logic        bvalid;
   logic        rvalid;
   logic        wdReq;
   logic        irq;
   int          n_fail      = 0;
   int          checks_done = 0;
   int          nReq        = 0;
   int          n;
   logic [31:0] d;
   logic [31:0] e;
   logic [31:0] v;
   logic [1:0]  r;
   logic [5:0]  regAdr [9] = '{`ADDR_MODE, `ADDR_RELOAD, `ADDR_COUNT, `ADDR_WARN,
      `ADDR_WINDOW, `ADDR_CLKDIV, `ADDR_INTSTAT, `ADDR_INTMASK, `ADDR_RSTFLAG};
   logic [31:0] regRst [9] = '{32'h0, `RELOAD_RST, `COUNT_RST, `WARN_RST,
      `WINDOW_RST, 32'h0, 32'h0, 32'h0, 32'h0};

   // clock, fast oscillator and reset-request pulse counter
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      osc <= ~osc;
      nReq <= nReq + int'(wdReq);
   end

   windowed_watchdog_timer #(.CNT_W(24), .DIV_W(8)) windowed_watchdog_timer_inst (
      .sys_clk(sys_clk), .rst(rst), .porRst(porRst), .alwaysOn1mhzOsc(osc),
      .deepSleep(deepSleep), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
      .wdResetReq(wdReq), .irq(irq));

   // expected stored reload value: floor at the shortest period
   function automatic logic [31:0] exp_reload(input logic [31:0] x);
      return (x[23:0] < `RELOAD_MIN) ? {8'h0, `RELOAD_MIN} : {8'h0, x[23:0]};
   endfunction : exp_reload

   // cycles to timeout: four ticks per count, two cycles per tick
   function automatic int per(input int rl);
      return (rl + 1) * 4 * 2;
   endfunction : per

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [5:0] a, input logic [31:0] x);
      logic aw;
      logic w;
      int   k;
      aw = 1'h1;
      w = 1'h1;
      awaddr <= a;
      wdata <= x;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (aw && awready) begin
            aw = 1'h0;
            awvalid <= 1'h0;
         end
         if (w && wready) begin
            w = 1'h0;
            wvalid <= 1'h0;
         end
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
      chk(k < 50, 1'h1);
   endtask : wr

   task automatic rd(input logic [5:0] a);
      logic ar;
      int   k;
      ar = 1'h1;
      araddr <= a;
      arvalid <= 1'h1;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (ar && arready) begin
            ar = 1'h0;
            arvalid <= 1'h0;
         end
         if (rvalid) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
      chk(k < 50, 1'h1);
   endtask : rd

   // poll until a masked bit is set, or with a zero mask until count <= lim
   task automatic poll(input logic [5:0] a, input logic [31:0] m, input logic [31:0] lim);
      for (int k = 0; k < 2000; k++) begin
         rd(a);
         if (m != 0 ? (d & m) != 0 : d[23:0] <= lim) break;
      end
   endtask : poll

   task automatic feed;
      wr(`ADDR_FEED, {24'h0, `FEED_KEY1});
      wr(`ADDR_FEED, {24'h0, `FEED_KEY2});
   endtask : feed

   task automatic do_reset(input logic por);
      rst <= 1'h1;
      porRst <= por;
      repeat (10) @(posedge sys_clk);
      rst <= 1'h0;
      porRst <= 1'h0;
      @(posedge sys_clk);
   endtask : do_reset

   // wait for irq or the reset request with a bound, cycle count in n
   task automatic wait_hi(input logic useReq);
      n = 0;
      while ((useReq ? wdReq : irq) !== 1'h1 && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
   endtask : wait_hi

   // hang guard
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_fail++;
      end_sim();
   end

   initial begin
      void'($urandom(71));
      do_reset(1'h1);
      // reset values, read-only counter, unmapped place
      foreach (regAdr[i]) begin
         rd(regAdr[i]);
         chk(d, regRst[i]);
      end
      rd(6'h28);
      chk(r, `RESP_SLVERR);
      chk(d, 32'h0);
      wr(`ADDR_COUNT, 32'h0);
      chk(r, `RESP_SLVERR);
      wr(6'h02, 32'h0);
      chk(r, `RESP_SLVERR);
      wr(`ADDR_RELOAD, 32'h10);
      chk(r, `RESP_OKAY);
      rd(`ADDR_RELOAD);
      chk(d, exp_reload(32'h10));
      for (int i = 0; i < 12; i++) begin
         v = $urandom;
         wr(`ADDR_RELOAD, v);
         rd(`ADDR_RELOAD);
         chk(d, exp_reload(v));
      end
      $display("test registers done");

      // interrupt on timeout, lock, mask and clear
      do_reset(1'h0);
      wr(`ADDR_RELOAD, 32'hFF);
      wr(`ADDR_INTMASK, 32'h1);
      wr(`ADDR_MODE, 32'h1);
      feed();
      wait_hi(1'h0);
      chk(n >= per(255) - 16 && n <= per(255) + 16, 1'h1);
      rd(`ADDR_INTSTAT);
      chk(d[0], 1'h1);
      chk(nReq, 0);
      wr(`ADDR_MODE, 32'h0);
      rd(`ADDR_MODE);
      chk(d[0], 1'h1);
      wr(`ADDR_INTMASK, 32'h0);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'h0);
      wr(`ADDR_INTMASK, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'h1);
      wr(`ADDR_INTSTAT, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'h0);
      $display("test timeout done");

      // warning point and protected reload value
      wr(`ADDR_MODE, 32'h5);
      wr(`ADDR_WARN, 32'h80);
      wr(`ADDR_INTSTAT, 32'h7);
      feed();
      wr(`ADDR_RELOAD, 32'h200);
      rd(`ADDR_RELOAD);
      chk(d, 32'hFF);
      poll(`ADDR_INTSTAT, 32'h2, 32'h0);
      chk(d[1:0], 2'h2);
      wr(`ADDR_RELOAD, 32'h200);
      rd(`ADDR_RELOAD);
      chk(d, 32'h200);
      // wrong second feed byte
      wr(`ADDR_INTSTAT, 32'h7);
      wr(`ADDR_FEED, {24'h0, `FEED_KEY1});
      wr(`ADDR_FEED, 32'h12);
      rd(`ADDR_INTSTAT);
      chk(d[2], 1'h1);
      $display("test warning done");

      // feed too early, then inside the window
      wr(`ADDR_WINDOW, 32'h40);
      wr(`ADDR_INTSTAT, 32'h7);
      feed();
      rd(`ADDR_INTSTAT);
      chk(d[2:0], 3'h4);
      poll(`ADDR_COUNT, 32'h0, 32'h40);
      wr(`ADDR_INTSTAT, 32'h7);
      feed();
      rd(`ADDR_INTSTAT);
      chk(d[2], 1'h0);
      $display("test window done");

      // deep sleep freezes the count unless run-in-sleep is set
      deepSleep <= 1'h1;
      rd(`ADDR_COUNT);
      e = d;
      repeat (80) @(posedge sys_clk);
      rd(`ADDR_COUNT);
      chk(d, e);
      wr(`ADDR_MODE, 32'h8);
      rd(`ADDR_COUNT);
      e = d;
      repeat (80) @(posedge sys_clk);
      rd(`ADDR_COUNT);
      chk(d < e, 1'h1);
      deepSleep <= 1'h0;
      // divide by four: ten counts in 320 cycles
      wr(`ADDR_WINDOW, 32'hFFFFFF);
      wr(`ADDR_CLKDIV, 32'h3);
      rd(`ADDR_COUNT);
      e = d;
      repeat (320) @(posedge sys_clk);
      rd(`ADDR_COUNT);
      chk(e - d >= 9 && e - d <= 11, 1'h1);
      $display("test sleep and divider done");

      // unfed timeout with reset enabled, flag kept over a later reset
      do_reset(1'h1);
      wr(`ADDR_RELOAD, 32'hFF);
      wr(`ADDR_MODE, 32'h3);
      feed();
      wait_hi(1'h1);
      chk(n >= per(255) - 16 && n <= per(255) + 16, 1'h1);
      @(posedge sys_clk);
      chk(wdReq, 1'h0);
      chk(nReq, 1);
      rd(`ADDR_RSTFLAG);
      chk(d, 32'h1);
      rd(`ADDR_MODE);
      chk(d, 32'h0);
      do_reset(1'h0);
      rd(`ADDR_RSTFLAG);
      chk(d, 32'h1);
      wr(`ADDR_RSTFLAG, 32'h1);
      rd(`ADDR_RSTFLAG);
      chk(d, 32'h0);
      $display("test chip reset done");
      end_sim();
   end
endmodule : windowed_watchdog_timer_tb
